// File: core/slc_latch_bank.sv
`timescale 1ns/1ps
// Summary of operation
// - select bits 00 send the word to the control latch.
// - first control write powers the device up and starts bias settling.
// - enable pin low disables the device at once, whatever the soft bits.
// - arm bit 1 with sync select 0 powers down immediately.
// - both bits 1: power down on second reference tick after strobe rise.
// - power-down loads counters, tristates pump, resets lock, unbiases rf, stops buffer.
// - shift register keeps accepting and latching words while powered down.
// - current field one is bits 16..14, field two bits 19..17.
// - gain select 1 picks current two, 0 picks current one.
// - mute-until-lock keeps rf outputs off until lock is reported.
// - pump tristate bit 1 tristates the charge pump.
// - polarity bit 1 positive, 0 negative for inverting filters.
// - counter clear bit holds reference and feedback counters in reset.
// - core bias select drives the oscillator core current level.
// - feedback divider sets ratio 3 to 8191.
// - reference divider sets ratio 1 to 16383.
// - lock needs five good cycles with count select 1, three with 0.
// - the shifted 24-bit word moves to its latch on strobe rise.
module slc_latch_bank
  import slc_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  arst_n,
  input  wire logic  serClk,
  input  wire logic  serData,
  input  wire logic  loadStrobe,
  input  wire logic  chipEnable,
  input  wire logic  refIn,
  input  wire logic  fbIn,
  input  wire logic  phaseOk,
  input  wire logic  phaseBad,
  output slc_analog_t analogCtrl,
  output logic       powerDown,
  output logic       lockFlag,
  output logic       monitorOut
);

  // ---------------------------------------------------------------
  // pin sampling and edges
  // ---------------------------------------------------------------
  logic [6:0]  pinSync;
  logic        serClkS;
  logic        serDataS;
  logic        loadS;
  logic        ceS;
  logic        refInS;
  logic        fbInS;
  logic        phaseOkS;
  logic        phaseBadS;
  logic        serClkPrev_r;
  logic        loadPrev_r;
  logic        refInPrev_r;
  logic        fbInPrev_r;
  logic        serRise;
  logic        loadRise;
  logic        refEdge;
  logic        fbEdge;

  slc_sync #(.W(7)) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       ({serClk, serData, loadStrobe, chipEnable, refIn, fbIn, phaseOk}),
    .q       (pinSync)
  );
  assign {serClkS, serDataS, loadS, ceS, refInS, fbInS, phaseOkS} = pinSync;

  // bad-phase flag shares the sampling depth of its partner
  logic phaseBadM_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseBadM_r <= 1'b0;
      phaseBadS   <= 1'b0;
    end else begin
      phaseBadM_r <= phaseBad;
      phaseBadS   <= phaseBadM_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serClkPrev_r <= 1'b0;
      loadPrev_r   <= 1'b0;
      refInPrev_r  <= 1'b0;
      fbInPrev_r   <= 1'b0;
    end else begin
      serClkPrev_r <= serClkS;
      loadPrev_r   <= loadS;
      refInPrev_r  <= refInS;
      fbInPrev_r   <= fbInS;
    end
  end

  assign serRise  = serClkS & ~serClkPrev_r;
  assign loadRise = loadS & ~loadPrev_r;
  assign refEdge  = refInS & ~refInPrev_r;
  assign fbEdge   = fbInS & ~fbInPrev_r;

  // ---------------------------------------------------------------
  // shift register and latches
  // ---------------------------------------------------------------
  logic [SLC_WORD_W-1:0] shiftReg_r;
  slc_ctrl_t             ctrl_r;
  slc_ref_t              refLatch_r;
  slc_fb_t               fbLatch_r;
  logic                  pumpGain_r;
  slc_ctrl_t             newCtrl;
  slc_fb_t               newFb;

  assign newCtrl = slc_ctrl_t'(shiftReg_r);
  assign newFb   = slc_fb_t'(shiftReg_r);

  // never gated by power-down so words still land
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shiftReg_r <= '0;
    end else if (serRise) begin
      shiftReg_r <= {shiftReg_r[SLC_WORD_W-2:0], serDataS};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= slc_ctrl_t'(SLC_CTRL_RST);
      refLatch_r <= slc_ref_t'(SLC_REF_RST);
      fbLatch_r  <= slc_fb_t'(SLC_FB_RST);
    end else if (loadRise) begin
      unique case (shiftReg_r[1:0])
        SLC_SEL_CTRL: ctrl_r     <= slc_ctrl_t'(shiftReg_r);
        SLC_SEL_REF:  refLatch_r <= slc_ref_t'(shiftReg_r);
        SLC_SEL_FB:   fbLatch_r  <= slc_fb_t'(shiftReg_r);
        SLC_SEL_TEST: ;  // factory latch, ignored
      endcase
    end
  end

  // gain bit follows whichever latch wrote it last
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pumpGain_r <= 1'b0;
    end else if (loadRise && shiftReg_r[1:0] == SLC_SEL_CTRL) begin
      pumpGain_r <= newCtrl.pumpGain;
    end else if (loadRise && shiftReg_r[1:0] == SLC_SEL_FB) begin
      pumpGain_r <= newFb.pumpGain;
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  logic       poweredUp_r;
  logic       swPd_r;
  logic       syncArm_r;
  logic [1:0] syncCnt_r;
  logic       pdActive;
  logic       ctrlWrite;
  logic       refTick;
  logic       fbTick;

  assign ctrlWrite = loadRise && shiftReg_r[1:0] == SLC_SEL_CTRL;
  assign pdActive  = !ceS || swPd_r || !poweredUp_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      poweredUp_r <= 1'b0;
    end else if (ctrlWrite) begin
      poweredUp_r <= 1'b1;
    end
  end

  // sync mode waits for the pump to be between corrections
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      swPd_r    <= 1'b0;
      syncArm_r <= 1'b0;
      syncCnt_r <= '0;
    end else if (ctrlWrite) begin
      syncCnt_r <= '0;
      if (!newCtrl.pdArm) begin
        swPd_r    <= 1'b0;
        syncArm_r <= 1'b0;
      end else if (!newCtrl.pdSyncSel) begin
        swPd_r    <= 1'b1;
        syncArm_r <= 1'b0;
      end else begin
        syncArm_r <= 1'b1;
      end
    end else if (syncArm_r && refTick) begin
      if (syncCnt_r == SLC_SYNC_PD_EDGE - 2'h1) begin
        swPd_r    <= 1'b1;
        syncArm_r <= 1'b0;
      end else begin
        syncCnt_r <= syncCnt_r + 2'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [13:0] refRatio;
  logic [12:0] fbRatio;
  logic        cntLoad;

  assign refRatio = (refLatch_r.refDiv < SLC_REF_MIN) ? SLC_REF_MIN : refLatch_r.refDiv;
  assign fbRatio  = (fbLatch_r.fbDiv < SLC_FB_MIN) ? SLC_FB_MIN : fbLatch_r.fbDiv;
  assign cntLoad  = pdActive || ctrl_r.counterClear;

  slc_div_counter #(.W(14)) u_ref_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .inTick  (refEdge),
    .load    (cntLoad),
    .ratio   (refRatio),
    .outTick (refTick)
  );

  slc_div_counter #(.W(13)) u_fb_div (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .inTick  (fbEdge),
    .load    (cntLoad),
    .ratio   (fbRatio),
    .outTick (fbTick)
  );

  // divider outputs as half-rate levels for the monitor pin
  logic refLevel_r;
  logic fbLevel_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      refLevel_r <= 1'b0;
      fbLevel_r  <= 1'b0;
    end else begin
      refLevel_r <= refLevel_r ^ refTick;
      fbLevel_r  <= fbLevel_r ^ fbTick;
    end
  end

  // ---------------------------------------------------------------
  // lock detect
  // ---------------------------------------------------------------
  logic [2:0] goodCnt_r;
  logic [2:0] lockTarget;

  assign lockTarget = refLatch_r.lockCount ? SLC_LOCK_LONG : SLC_LOCK_SHORT;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      goodCnt_r <= '0;
      lockFlag  <= 1'b0;
    end else if (pdActive) begin
      goodCnt_r <= '0;
      lockFlag  <= 1'b0;
    end else if (refTick) begin
      if (phaseBadS) begin
        goodCnt_r <= '0;
        lockFlag  <= 1'b0;
      end else if (!lockFlag && phaseOkS) begin
        if (goodCnt_r + 3'h1 >= lockTarget) begin
          lockFlag <= 1'b1;
        end
        goodCnt_r <= goodCnt_r + 3'h1;
      end else if (!lockFlag) begin
        goodCnt_r <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // analog controls and outputs
  // ---------------------------------------------------------------
  slc_analog_t analog_nxt;

  always_comb begin
    analog_nxt.pumpCurrent  = pumpGain_r ? ctrl_r.pumpCurTwo : ctrl_r.pumpCurOne;
    analog_nxt.pumpTristate = pdActive || ctrl_r.pumpTristate;
    analog_nxt.detPolarity  = ctrl_r.detPolarity;
    analog_nxt.rfLevel      = ctrl_r.rfLevel;
    analog_nxt.rfBiasOn     = !pdActive && !(ctrl_r.muteUntilLock && !lockFlag);
    analog_nxt.coreBias     = ctrl_r.coreBias;
    analog_nxt.refBufOn     = !pdActive;
    analog_nxt.pulseWidth   = refLatch_r.pulseWidth;
    analog_nxt.bandClkDiv   = refLatch_r.bandClkDiv;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      analogCtrl <= '{pumpTristate: 1'b1, default: '0}; // down in reset, pump parked
      powerDown  <= 1'b1;
    end else begin
      analogCtrl <= analog_nxt;
      powerDown  <= pdActive;
    end
  end

  // unlisted codes read low rather than float
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      monitorOut <= 1'b0;
    end else begin
      unique case (ctrl_r.monitorSel)
        SLC_MON_LOCK: monitorOut <= lockFlag;
        SLC_MON_FB:   monitorOut <= fbLevel_r;
        SLC_MON_REF:  monitorOut <= refLevel_r;
        SLC_MON_HIGH: monitorOut <= 1'b1;
        default:      monitorOut <= 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence s_async_write;
    ctrlWrite && newCtrl.pdArm && !newCtrl.pdSyncSel;
  endsequence

  sequence s_second_tick;
    syncArm_r && refTick && !ctrlWrite && syncCnt_r == 2'h1;
  endsequence

  sequence s_first_tick;
    syncArm_r && !swPd_r && refTick && !ctrlWrite && syncCnt_r == 2'h0;
  endsequence

  chk_ctrl_route: assert property (
    ctrlWrite |=> ctrl_r == $past(shiftReg_r))
    else $error("control word not routed");

  chk_enable_low: assert property (
    !ceS |=> powerDown)
    else $error("enable low did not power down");

  chk_async_pd: assert property (
    s_async_write |-> ##2 powerDown)
    else $error("async power-down late");

  chk_sync_pd: assert property (
    s_second_tick |-> ##2 powerDown)
    else $error("sync power-down missed second tick");

  chk_sync_wait: assert property (
    s_first_tick |=> !swPd_r)
    else $error("sync power-down too early");

  chk_pd_forces: assert property (
    powerDown |-> analogCtrl.pumpTristate && !analogCtrl.rfBiasOn && !analogCtrl.refBufOn && !lockFlag)
    else $error("power-down effects missing");

  chk_gain_select: assert property (
    ##1 analogCtrl.pumpCurrent == ($past(pumpGain_r) ? $past(ctrl_r.pumpCurTwo) : $past(ctrl_r.pumpCurOne)))
    else $error("pump current wrong setting");

  chk_mute_lock: assert property (
    ctrl_r.muteUntilLock && !lockFlag |=> !analogCtrl.rfBiasOn)
    else $error("rf on before lock");

  chk_clear_hold: assert property (
    ctrl_r.counterClear |=> !refTick && !fbTick)
    else $error("counters ran while cleared");

  chk_shift_pd: assert property (
    powerDown && serRise |=> shiftReg_r[0] == $past(serDataS))
    else $error("shift stalled in power-down");

endmodule

// File: core/slc_pkg.sv
package slc_pkg;

  // ---------------------------------------------------------------
  // word and latch selection
  // ---------------------------------------------------------------
  localparam int        SLC_WORD_W   = 24;
  localparam logic [1:0] SLC_SEL_CTRL = 2'h0;
  localparam logic [1:0] SLC_SEL_REF  = 2'h1;
  localparam logic [1:0] SLC_SEL_FB   = 2'h2;
  localparam logic [1:0] SLC_SEL_TEST = 2'h3;

  // ---------------------------------------------------------------
  // latch layouts, msb first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rsv;
    logic       pdSyncSel;
    logic       pdArm;
    logic [2:0] pumpCurTwo;
    logic [2:0] pumpCurOne;
    logic [1:0] rfLevel;
    logic       muteUntilLock;
    logic       pumpGain;
    logic       pumpTristate;
    logic       detPolarity;
    logic [2:0] monitorSel;
    logic       counterClear;
    logic [1:0] coreBias;
    logic [1:0] latchSel;
  } slc_ctrl_t;

  typedef struct packed {
    logic [1:0]  rsv;
    logic [1:0]  bandClkDiv;
    logic        testFlag;
    logic        lockCount;
    logic [1:0]  pulseWidth;
    logic [13:0] refDiv;
    logic [1:0]  latchSel;
  } slc_ref_t;

  typedef struct packed {
    logic [1:0]  rsv;
    logic        pumpGain;
    logic [12:0] fbDiv;
    logic [5:0]  rsvLow;
    logic [1:0]  latchSel;
  } slc_fb_t;

  // analog-facing control word
  typedef struct packed {
    logic [2:0] pumpCurrent;
    logic       pumpTristate;
    logic       detPolarity;
    logic [1:0] rfLevel;
    logic       rfBiasOn;
    logic [1:0] coreBias;
    logic       refBufOn;
    logic [1:0] pulseWidth;
    logic [1:0] bandClkDiv;
  } slc_analog_t;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [23:0] SLC_CTRL_RST     = 24'h000000;
  localparam logic [23:0] SLC_REF_RST      = 24'h000001;
  localparam logic [23:0] SLC_FB_RST       = 24'h000002;
  localparam logic [13:0] SLC_REF_MIN      = 14'h0001;
  localparam logic [12:0] SLC_FB_MIN       = 13'h0003;
  localparam logic [2:0]  SLC_LOCK_SHORT   = 3'h3;
  localparam logic [2:0]  SLC_LOCK_LONG    = 3'h5;
  localparam logic [1:0]  SLC_SYNC_PD_EDGE = 2'h2;

  // monitor pin selections
  localparam logic [2:0] SLC_MON_LOW  = 3'h0;
  localparam logic [2:0] SLC_MON_LOCK = 3'h1;
  localparam logic [2:0] SLC_MON_FB   = 3'h2;
  localparam logic [2:0] SLC_MON_REF  = 3'h4;
  localparam logic [2:0] SLC_MON_HIGH = 3'h7;

endpackage

// File: core/slc_sync.sv
`timescale 1ns/1ps
module slc_sync
  import slc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// File: core/slc_div_counter.sv
`timescale 1ns/1ps
module slc_div_counter
  import slc_pkg::*;
#(
  parameter int W = 14
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         inTick,
  input  wire logic         load,
  input  wire logic [W-1:0] ratio,
  output logic              outTick
);
  logic [W-1:0] cnt_r;

  // load state holds the count at the ratio and emits nothing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r   <= '0;
      outTick <= 1'b0;
    end else if (load) begin
      cnt_r   <= ratio;
      outTick <= 1'b0;
    end else if (inTick) begin
      if (cnt_r <= W'(1)) begin
        cnt_r   <= ratio;
        outTick <= 1'b1;
      end else begin
        cnt_r   <= cnt_r - W'(1);
        outTick <= 1'b0;
      end
    end else begin
      outTick <= 1'b0;
    end
  end
endmodule

// File: verification/slc_host_model.sv
`timescale 1ns/1ps
module slc_host_model
  import slc_pkg::*;
(
  input  wire logic ref_clk,
  output logic      serClk,
  output logic      serData,
  output logic      loadStrobe
);
  // ---------------------------------------------------------------
  // serial host, link clock 160 ns
  // ---------------------------------------------------------------
  localparam int HALF = 4;

  initial begin
    serClk     = 1'b0;
    serData    = 1'b0;
    loadStrobe = 1'b0;
  end

  // link clock parks low between frames; data moves well clear of its rise
  task automatic send_word(input logic [SLC_WORD_W-1:0] w);
    @(posedge ref_clk);
    #1;
    for (int i = SLC_WORD_W - 1; i >= 0; i--) begin
      serData = w[i];
      repeat (HALF) @(posedge ref_clk);
      #1 serClk = 1'b1;
      repeat (HALF) @(posedge ref_clk);
      #1 serClk = 1'b0;
    end
    repeat (HALF) @(posedge ref_clk);
    #1 loadStrobe = 1'b1;
    // released data line has no pull: show the inverse, not the last bit
    serData = ~w[0];
    repeat (HALF) @(posedge ref_clk);
    #1 loadStrobe = 1'b0;
    repeat (HALF) @(posedge ref_clk);
  endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps
module testbench
  import slc_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, reset, pins
  // ---------------------------------------------------------------
  localparam int LIMIT = 40000;

  logic        ref_clk    = 1'b0;
  logic        arst_n     = 1'b0;
  logic        chipEnable = 1'b1;
  logic        refIn      = 1'b0;
  logic        phaseOk    = 1'b1;
  logic        fbIn       = 1'b0;
  logic        phaseBad   = 1'b0;
  logic        serClk;
  logic        serData;
  logic        loadStrobe;
  slc_analog_t analogCtrl;
  logic        powerDown;
  logic        lockFlag;
  logic        monitorOut;
  int          failCount  = 0;
  int          nTests     = 0;
  int          cycles     = 0;

  always #10 ref_clk = ~ref_clk;

  slc_host_model host (.ref_clk(ref_clk), .serClk(serClk), .serData(serData), .loadStrobe(loadStrobe));

  slc_latch_bank DUT (
    .ref_clk(ref_clk), .arst_n(arst_n), .serClk(serClk), .serData(serData),
    .loadStrobe(loadStrobe), .chipEnable(chipEnable), .refIn(refIn), .fbIn(fbIn),
    .phaseOk(phaseOk), .phaseBad(phaseBad), .analogCtrl(analogCtrl), .powerDown(powerDown),
    .lockFlag(lockFlag), .monitorOut(monitorOut)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wrap_up();
    if (failCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failCount++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] expv);
    nTests++;
    if (seen !== expv) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic send(input logic [23:0] w);
    host.send_word(w);
    tick(1);
  endtask

  // layout built from the bit map, not from the package struct
  function automatic logic [23:0] ctrl_word(input logic arm, sync, mute, gain, clr, input logic [2:0] mon);
    return {2'h0, sync, arm, 3'h2, 3'h5, 2'h3, mute, gain, 1'b0, 1'b1, mon, clr, 2'h1, SLC_SEL_CTRL};
  endfunction

  task automatic pulses(input int n);
    repeat (n) begin
      refIn = 1'b1;
      tick(4);
      refIn = 1'b0;
      tick(4);
    end
    tick(4);
  endtask

  task automatic chk_analog(input logic [2:0] cur, input logic tri3, bias, refBuf);
    check("pumpCurrent", analogCtrl.pumpCurrent, cur);
    check("pumpTristate", analogCtrl.pumpTristate, tri3);
    check("rfBiasOn", analogCtrl.rfBiasOn, bias);
    check("refBufOn", analogCtrl.refBufOn, refBuf);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_power_up();
    send({2'h0, 2'h1, 1'b0, 1'b0, 2'h2, 14'h0001, SLC_SEL_REF});
    check("powerDown", powerDown, 1'b1);
    send(ctrl_word(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h7));
    check("powerDown", powerDown, 1'b0);
    check("analogCtrl", analogCtrl, {3'h5, 1'b0, 1'b1, 2'h3, 1'b0, 2'h1, 1'b1, 2'h2, 2'h1});
    check("monitorOut", monitorOut, 1'b1);
    tick(30000);  // short settling interval, smaller capacitor
    send({2'h0, 1'b1, 13'h0010, 6'h00, SLC_SEL_FB});
    check("pumpCurrent", analogCtrl.pumpCurrent, 3'h2);
  endtask

  task automatic test_lock_mute();
    pulses(2);
    check("lockFlag", lockFlag, 1'b0);
    check("rfBiasOn", analogCtrl.rfBiasOn, 1'b0);
    pulses(1);
    check("lockFlag", lockFlag, 1'b1);
    check("rfBiasOn", analogCtrl.rfBiasOn, 1'b1);
  endtask

  task automatic test_async_pd();
    send(ctrl_word(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h7));
    check("powerDown", powerDown, 1'b1);
    chk_analog(3'h5, 1'b1, 1'b0, 1'b0);
    check("lockFlag", lockFlag, 1'b0);
    // feedback latch left untouched while down
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7));
    check("powerDown", powerDown, 1'b0);
    chk_analog(3'h5, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic test_ignored_select();
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0) | 24'h000003);
    check("monitorOut", monitorOut, 1'b1);
  endtask

  task automatic test_sync_pd();
    send(ctrl_word(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 3'h7));
    check("powerDown", powerDown, 1'b0);
    pulses(1);
    check("powerDown", powerDown, 1'b0);
    pulses(1);
    check("powerDown", powerDown, 1'b1);
    chk_analog(3'h5, 1'b1, 1'b0, 1'b0);
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7));
  endtask

  task automatic test_chip_enable();
    chipEnable = 1'b0;
    tick(6);
    check("powerDown", powerDown, 1'b1);
    chipEnable = 1'b1;
    tick(6);
    check("powerDown", powerDown, 1'b0);
  endtask

  task automatic test_counter_clear();
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h7));
    pulses(4);
    check("lockFlag", lockFlag, 1'b0);
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h7));
    pulses(3);
    check("lockFlag", lockFlag, 1'b1);
  endtask

  task automatic fb_pulses(input int n);
    repeat (n) begin
      fbIn = 1'b1;
      tick(4);
      fbIn = 1'b0;
      tick(4);
    end
  endtask

  // five-tick lock at divide-by-2, after a bad phase drops the old lock
  task automatic test_lock_count();
    send({2'h0, 2'h1, 1'b0, 1'b1, 2'h2, 14'h0002, SLC_SEL_REF});
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h1));
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h1));
    phaseBad = 1'b1;
    pulses(2);
    phaseBad = 1'b0;
    check("lockFlag", lockFlag, 1'b0);
    check("monitorOut", monitorOut, 1'b0);
    pulses(8);
    check("lockFlag", lockFlag, 1'b0);
    pulses(2);
    check("lockFlag", lockFlag, 1'b1);
    check("monitorOut", monitorOut, 1'b1);
  endtask

  // feedback divider of 16 seen through the monitor pin
  task automatic test_monitor_fb();
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0));
    check("monitorOut", monitorOut, 1'b0);
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2));
    send(ctrl_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h2));
    fb_pulses(15);
    check("monitorOut", monitorOut, 1'b0);
    fb_pulses(1);
    check("monitorOut", monitorOut, 1'b1);
  endtask

  initial begin
    tick(1);
    check("powerDown", powerDown, 1'b1);
    check("analogCtrl", analogCtrl, 24'h000800);
    check("lockFlag", lockFlag, 1'b0);
    tick(1);
    arst_n = 1'b1;
    tick(1);
    test_power_up();
    test_lock_mute();
    test_async_pd();
    test_ignored_select();
    test_sync_pd();
    test_chip_enable();
    test_counter_clear();
    test_lock_count();
    test_monitor_fb();
    wrap_up();
  end
endmodule
